// ---- hdl/lslc_pkg.sv ----
// Package: register map, fields, reset values and mode codes for the lane/PLL control block
package lslc_pkg;
  // ----------------------------------------
  // Register addresses (management serial interface, 5-bit register space)
  // ----------------------------------------
  localparam logic [4:0] LSLC_ADDR_PLL_CTRL = 5'h06;
  localparam logic [4:0] LSLC_ADDR_LANE_B = 5'h07;
  localparam logic [4:0] LSLC_ADDR_LANE_C = 5'h08;
  localparam int LSLC_LANES = 4;

  // ----------------------------------------
  // Field positions in the PLL control register
  // ----------------------------------------
  localparam int LSLC_MASK_LSB = 12;
  localparam int LSLC_RSVD_HI_LSB = 10;
  localparam int LSLC_BW_LSB = 8;
  localparam int LSLC_FAR_LOOP_BIT = 7;
  localparam int LSLC_RSVD_LO_LSB = 5;
  localparam int LSLC_PLL_ON_BIT = 4;
  localparam int LSLC_MPY_LSB = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] LSLC_PLL_CTRL_RST = 16'hF115;
  localparam logic [3:0] LSLC_MASK_RST = 4'hF;
  localparam logic [1:0] LSLC_BW_RST = 2'h1;
  localparam logic LSLC_FAR_LOOP_RST = 1'b0;
  localparam logic LSLC_PLL_ON_RST = 1'b1;
  localparam logic [3:0] LSLC_MPY_RST = 4'h5;
  localparam logic [1:0] LSLC_RSVD_RST = 2'h0;
  localparam logic [15:0] LSLC_LANE_B_RST = 16'hDC04;
  localparam logic [15:0] LSLC_LANE_C_RST = 16'h0000;

  // ----------------------------------------
  // Loop bandwidth codes
  // ----------------------------------------
  localparam logic [1:0] LSLC_BW_NO_CLEANER = 2'h1;
  localparam logic [1:0] LSLC_BW_CLEANER = 2'h2;

  // ----------------------------------------
  // Far-end loopback modes: {low-side bit, companion bit}
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSLC_LOOP_OFF = 2'h0,
    LSLC_LOOP_PAD = 2'h1,
    LSLC_LOOP_DIG_DRV_OFF = 2'h2,
    LSLC_LOOP_DIG_DRV_ON = 2'h3
  } lslc_loop_type;

  // ----------------------------------------
  // Multiplier factors in tenths (0 marks a reserved code)
  // ----------------------------------------
  localparam logic [9:0] LSLC_MPY_RESERVED = 10'h000;
endpackage

// ---- hdl/lslc_mpy_decode.sv ----
// Multiplier code decoder: code to factor in tenths, with reserved flag
`timescale 1ns/1ps
module lslc_mpy_decode (
  // Code in
  input wire logic [3:0] code,
  // Decoded factor
  output logic [9:0] factor_x10,
  output logic reserved
);
  import lslc_pkg::*;

  // Table decode; reserved codes give zero
  always_comb begin
    case (code)
      4'h0: factor_x10 = 10'd40;
      4'h1: factor_x10 = 10'd50;
      4'h2: factor_x10 = 10'd60;
      4'h4: factor_x10 = 10'd80;
      4'h5: factor_x10 = 10'd100;
      4'h6: factor_x10 = 10'd120;
      4'h7: factor_x10 = 10'd125;
      4'h8: factor_x10 = 10'd150;
      4'h9: factor_x10 = 10'd200;
      4'hA: factor_x10 = 10'd250;
      4'hD: factor_x10 = 10'd500;
      4'hE: factor_x10 = 10'd650;
      default: factor_x10 = LSLC_MPY_RESERVED;
    endcase
    reserved = (factor_x10 == LSLC_MPY_RESERVED);
  end
endmodule

// ---- hdl/lslc_ctrl.sv ----
// Low speed lane/PLL control register with per-lane companion registers
`timescale 1ns/1ps
module lslc_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register access port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Power-down controls
  input wire logic channel_powerdown_n,
  input wire logic global_powerdown,
  // Companion loopback bit from another register
  input wire logic far_loop_mode_companion,
  // PLL controls
  output logic pll_enable,
  output logic [3:0] pll_multiplier_code,
  output logic [9:0] pll_factor_x10,
  output logic pll_code_reserved,
  output logic [1:0] pll_loop_bw_select,
  // Loopback path controls
  output logic loop_pad_path,
  output logic loop_digital_path,
  output logic out_driver_enable,
  // Per-lane companion settings
  output logic [15:0] lane_control_b [lslc_pkg::LSLC_LANES],
  output logic [15:0] lane_control_c [lslc_pkg::LSLC_LANES]
);
  import lslc_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0] lane_access_mask_r, lane_access_mask_nxt;
  logic [1:0] rsvd_hi_r, rsvd_hi_nxt;
  logic [1:0] loop_bw_r, loop_bw_nxt;
  logic far_loop_mode_low_r, far_loop_mode_low_nxt;
  logic [1:0] rsvd_lo_r, rsvd_lo_nxt;
  logic low_side_pll_on_r, low_side_pll_on_nxt;
  logic [3:0] mpy_r, mpy_nxt;
  logic [15:0] lane_b_r [LSLC_LANES];
  logic [15:0] lane_b_nxt [LSLC_LANES];
  logic [15:0] lane_c_r [LSLC_LANES];
  logic [15:0] lane_c_nxt [LSLC_LANES];
  logic [15:0] ctrl_word;
  logic [15:0] sel_b, sel_c;
  logic [15:0] rdata_nxt;
  logic [9:0] factor_w;
  logic reserved_w;
  lslc_loop_type loop_mode;
  logic pll_enable_nxt, pad_nxt, dig_nxt, drv_nxt;

  // Assembled view of the control register
  assign ctrl_word = {lane_access_mask_r, rsvd_hi_r, loop_bw_r, far_loop_mode_low_r,
                      rsvd_lo_r, low_side_pll_on_r, mpy_r};

  // ----------------------------------------
  // Control register next state
  // ----------------------------------------
  always_comb begin
    lane_access_mask_nxt = lane_access_mask_r;
    rsvd_hi_nxt = rsvd_hi_r;
    loop_bw_nxt = loop_bw_r;
    far_loop_mode_low_nxt = far_loop_mode_low_r;
    rsvd_lo_nxt = rsvd_lo_r;
    low_side_pll_on_nxt = low_side_pll_on_r;
    mpy_nxt = mpy_r;
    if (reg_wr && reg_addr == LSLC_ADDR_PLL_CTRL) begin
      lane_access_mask_nxt = reg_wdata[LSLC_MASK_LSB +: 4];
      rsvd_hi_nxt = reg_wdata[LSLC_RSVD_HI_LSB +: 2];
      rsvd_lo_nxt = reg_wdata[LSLC_RSVD_LO_LSB +: 2];
      loop_bw_nxt = reg_wdata[LSLC_BW_LSB +: 2];
      far_loop_mode_low_nxt = reg_wdata[LSLC_FAR_LOOP_BIT];
      low_side_pll_on_nxt = reg_wdata[LSLC_PLL_ON_BIT];
      mpy_nxt = reg_wdata[LSLC_MPY_LSB +: 4];
    end
  end

  // Plain registering; reset values from the package
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lane_access_mask_r <= LSLC_MASK_RST;
      rsvd_hi_r <= LSLC_RSVD_RST;
      loop_bw_r <= LSLC_BW_RST;
      far_loop_mode_low_r <= LSLC_FAR_LOOP_RST;
      rsvd_lo_r <= LSLC_RSVD_RST;
      low_side_pll_on_r <= LSLC_PLL_ON_RST;
      mpy_r <= LSLC_MPY_RST;
    end else begin
      lane_access_mask_r <= lane_access_mask_nxt;
      rsvd_hi_r <= rsvd_hi_nxt;
      loop_bw_r <= loop_bw_nxt;
      far_loop_mode_low_r <= far_loop_mode_low_nxt;
      rsvd_lo_r <= rsvd_lo_nxt;
      low_side_pll_on_r <= low_side_pll_on_nxt;
      mpy_r <= mpy_nxt;
    end
  end

  // ----------------------------------------
  // Per-lane companion copies
  // ----------------------------------------
  // one storage copy per lane
  genvar ln;
  generate
    for (ln = 0; ln < LSLC_LANES; ln++) begin : g_lane
      always_comb begin
        lane_b_nxt[ln] = lane_b_r[ln];
        lane_c_nxt[ln] = lane_c_r[ln];
        if (reg_wr && lane_access_mask_r[ln]) begin
          if (reg_addr == LSLC_ADDR_LANE_B) begin
            lane_b_nxt[ln] = reg_wdata;
          end
          if (reg_addr == LSLC_ADDR_LANE_C) begin
            lane_c_nxt[ln] = reg_wdata;
          end
        end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          lane_b_r[ln] <= LSLC_LANE_B_RST;
          lane_c_r[ln] <= LSLC_LANE_C_RST;
        end else begin
          lane_b_r[ln] <= lane_b_nxt[ln];
          lane_c_r[ln] <= lane_c_nxt[ln];
        end
      end

      assign lane_control_b[ln] = lane_b_r[ln];
      assign lane_control_c[ln] = lane_c_r[ln];
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // one-hot select; other masks give an OR, undefined to software
  always_comb begin
    sel_b = 16'h0000;
    sel_c = 16'h0000;
    for (int i = 0; i < LSLC_LANES; i++) begin
      if (lane_access_mask_r[i]) begin
        sel_b = sel_b | lane_b_r[i];
        sel_c = sel_c | lane_c_r[i];
      end
    end
    case (reg_addr)
      LSLC_ADDR_PLL_CTRL: rdata_nxt = ctrl_word;
      LSLC_ADDR_LANE_B: rdata_nxt = sel_b;
      LSLC_ADDR_LANE_C: rdata_nxt = sel_c;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read data held until next read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // PLL and loopback controls
  // ----------------------------------------
  // multiplier factor decode
  lslc_mpy_decode u_mpy (
    .code(mpy_r),
    .factor_x10(factor_w),
    .reserved(reserved_w)
  );

  always_comb begin
    loop_mode = lslc_loop_type'({far_loop_mode_low_r, far_loop_mode_companion});
    pll_enable_nxt = low_side_pll_on_r && channel_powerdown_n && !global_powerdown;
    pad_nxt = 1'b0;
    dig_nxt = 1'b0;
    drv_nxt = 1'b1;
    case (loop_mode)
      LSLC_LOOP_OFF: pad_nxt = 1'b0;
      // pad path; partner keeps inputs idle
      LSLC_LOOP_PAD: pad_nxt = 1'b1;
      // digital path, driver off to save power
      LSLC_LOOP_DIG_DRV_OFF: begin
        dig_nxt = 1'b1;
        drv_nxt = 1'b0;
      end
      LSLC_LOOP_DIG_DRV_ON: dig_nxt = 1'b1;
      default: pad_nxt = 1'b0;
    endcase
  end

  // Outputs registered for clean timing
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pll_enable <= 1'b0;
      pll_multiplier_code <= LSLC_MPY_RST;
      pll_factor_x10 <= 10'h000;
      pll_code_reserved <= 1'b0;
      pll_loop_bw_select <= LSLC_BW_RST;
      loop_pad_path <= 1'b0;
      loop_digital_path <= 1'b0;
      out_driver_enable <= 1'b1;
    end else begin
      pll_enable <= pll_enable_nxt;
      pll_multiplier_code <= mpy_r;
      pll_factor_x10 <= factor_w;
      pll_code_reserved <= reserved_w;
      pll_loop_bw_select <= loop_bw_r;
      loop_pad_path <= pad_nxt;
      loop_digital_path <= dig_nxt;
      out_driver_enable <= drv_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MASKED_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_LANE_B && !lane_access_mask_r[0]) |=> $stable(lane_b_r[0]))
    else $error("masked lane 0 changed");
  AST_MASK_RESET: assert property (@(posedge sys_clk)
    $fell(reset) |-> lane_access_mask_r == 4'hF)
    else $error("mask not all ones after reset");
  AST_ONEHOT_READ: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_rd && reg_addr == LSLC_ADDR_LANE_C && lane_access_mask_r == 4'h4) |=> reg_rdata == $past(lane_c_r[2]))
    else $error("read not from selected lane");
  AST_PD_FORCE: assert property (@(posedge sys_clk) disable iff (reset)
    (!channel_powerdown_n || global_powerdown) |=> !pll_enable)
    else $error("PLL on during power-down");
  AST_PLL_ON: assert property (@(posedge sys_clk) disable iff (reset)
    (channel_powerdown_n && !global_powerdown && low_side_pll_on_r) |=> pll_enable)
    else $error("PLL not enabled");
  AST_LOOP_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    (!far_loop_mode_low_r && !far_loop_mode_companion) |=> (!loop_pad_path && !loop_digital_path))
    else $error("loopback active with code 00");
  AST_PAD_LOOP: assert property (@(posedge sys_clk) disable iff (reset)
    (!far_loop_mode_low_r && far_loop_mode_companion) |=> (loop_pad_path && out_driver_enable))
    else $error("pad loopback not selected");
  AST_DIG_DRV_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    (far_loop_mode_low_r && !far_loop_mode_companion) |=> (loop_digital_path && !out_driver_enable))
    else $error("driver not disabled");
  AST_DIG_DRV_ON: assert property (@(posedge sys_clk) disable iff (reset)
    (far_loop_mode_low_r && far_loop_mode_companion) |=> (loop_digital_path && out_driver_enable))
    else $error("driver not running");
  AST_MPY_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_PLL_CTRL) |=> ##1 pll_multiplier_code == $past(reg_wdata[3:0], 2))
    else $error("multiplier not updated");
  AST_RSVD_RW: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_PLL_CTRL) |=> rsvd_hi_r == $past(reg_wdata[11:10]))
    else $error("reserved field not stored");
  AST_BW_OUT: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_PLL_CTRL) |=> ##1 pll_loop_bw_select == $past(reg_wdata[9:8], 2))
    else $error("bandwidth not passed out");
  AST_MPY_DECODE: assert property (@(posedge sys_clk) disable iff (reset)
    (mpy_r == 4'h5) |=> pll_factor_x10 == 10'd100)
    else $error("code 0101 not 10x");
  AST_LANE_TAKES_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_LANE_C && lane_access_mask_r[3]) |=> lane_c_r[3] == $past(reg_wdata))
    else $error("enabled lane 3 missed a write");
  AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == LSLC_ADDR_PLL_CTRL) |=> lane_access_mask_r == $past(reg_wdata[15:12]))
    else $error("lane mask not stored");
  AST_RESERVED_CODE: assert property (@(posedge sys_clk) disable iff (reset)
    (mpy_r == 4'hF) |=> pll_code_reserved)
    else $error("code 1111 not flagged reserved");
endmodule

// ---- tb/lslc_ctrl_test.sv ----
// Self-checking bench for the lane/PLL control register block
`timescale 1ns/1ps
module lslc_ctrl_test;
  import lslc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic channel_powerdown_n = 1'b1;
  logic global_powerdown = 1'b0;
  logic far_loop_mode_companion = 1'b0;
  logic pll_enable, pll_code_reserved, loop_pad_path, loop_digital_path, out_driver_enable;
  logic [3:0] pll_multiplier_code;
  logic [9:0] pll_factor_x10;
  logic [1:0] pll_loop_bw_select;
  logic [15:0] lane_control_b [LSLC_LANES];
  logic [15:0] lane_control_c [LSLC_LANES];
  logic [15:0] ctl_m, rd, b_m [4], c_m [4];
  logic [9:0] fx;
  logic [1:0] md;
  integer seed = 32'h095c625b;
  integer err_total = 0;
  integer samples_checked = 0;
  integer i, k;

  lslc_ctrl lslc_ctrl_inst (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .channel_powerdown_n(channel_powerdown_n), .global_powerdown(global_powerdown),
    .far_loop_mode_companion(far_loop_mode_companion), .pll_enable(pll_enable),
    .pll_multiplier_code(pll_multiplier_code), .pll_factor_x10(pll_factor_x10),
    .pll_code_reserved(pll_code_reserved), .pll_loop_bw_select(pll_loop_bw_select),
    .loop_pad_path(loop_pad_path), .loop_digital_path(loop_digital_path),
    .out_driver_enable(out_driver_enable), .lane_control_b(lane_control_b), .lane_control_c(lane_control_c));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Factor in tenths, zero for reserved codes
  function automatic logic [9:0] factor_of(input logic [3:0] c);
    case (c)
      4'h0: factor_of = 10'd40;
      4'h1: factor_of = 10'd50;
      4'h2: factor_of = 10'd60;
      4'h4: factor_of = 10'd80;
      4'h5: factor_of = 10'd100;
      4'h6: factor_of = 10'd120;
      4'h7: factor_of = 10'd125;
      4'h8: factor_of = 10'd150;
      4'h9: factor_of = 10'd200;
      4'hA: factor_of = 10'd250;
      4'hD: factor_of = 10'd500;
      4'hE: factor_of = 10'd650;
      default: factor_of = 10'd0;
    endcase
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes rise 2 ns after an edge and drop after the taking edge
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #2 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #2 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #2 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #2 reg_rd = 1'b0;
    check({15'h0, reg_rvalid}, 16'h0001);
    d = reg_rdata;
  endtask

  task automatic set_ctl(input logic [15:0] v);
    reg_write(LSLC_ADDR_PLL_CTRL, v);
    ctl_m = v;
  endtask

  // Outputs follow the register one cycle later, so let two edges pass
  task automatic check_outputs();
    repeat (2) @(posedge sys_clk);
    #1 fx = factor_of(ctl_m[3:0]);
    md = {ctl_m[7], far_loop_mode_companion};
    check({15'h0, pll_enable}, {15'h0, ctl_m[4] & channel_powerdown_n & ~global_powerdown});
    check({12'h0, pll_multiplier_code}, {12'h0, ctl_m[3:0]});
    check({6'h0, pll_factor_x10}, {6'h0, fx});
    check({15'h0, pll_code_reserved}, {15'h0, fx == 10'd0});
    check({14'h0, pll_loop_bw_select}, {14'h0, ctl_m[9:8]});
    check({15'h0, loop_pad_path}, {15'h0, md == 2'h1});
    check({15'h0, loop_digital_path}, {15'h0, md[1]});
    check({15'h0, out_driver_enable}, {15'h0, md != 2'h2});
  endtask

  task automatic check_lanes();
    for (int j = 0; j < 4; j++) begin
      check(lane_control_b[j], b_m[j]);
      check(lane_control_c[j], c_m[j]);
      reg_write(LSLC_ADDR_PLL_CTRL, {4'h1 << j, ctl_m[11:0]});
      reg_read(LSLC_ADDR_LANE_B, rd);
      check(rd, b_m[j]);
      reg_read(LSLC_ADDR_LANE_C, rd);
      check(rd, c_m[j]);
    end
    reg_write(LSLC_ADDR_PLL_CTRL, ctl_m);
  endtask

  task automatic do_reset();
    #2 reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2 reset = 1'b0;
    ctl_m = LSLC_PLL_CTRL_RST;
    for (int j = 0; j < 4; j++) begin
      b_m[j] = LSLC_LANE_B_RST;
      c_m[j] = LSLC_LANE_C_RST;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 1k cycles, limit at 10k
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    reg_read(LSLC_ADDR_PLL_CTRL, rd);
    check(rd, 16'hF115);
    check_outputs();
    check_lanes();
    // Unmapped address reads zero and ignores writes
    reg_write(5'h09, 16'hFFFF);
    reg_read(5'h09, rd);
    check(rd, 16'h0000);
    reg_read(LSLC_ADDR_PLL_CTRL, rd);
    check(rd, ctl_m);
    // test enables on every lane before any loopback
    reg_write(LSLC_ADDR_LANE_C, 16'h000C);
    for (i = 0; i < 4; i++) c_m[i] = 16'h000C;
    // Sweep every multiplier code and loop mode with random other fields
    // no low speed data driven, partner lines stay idle
    for (k = 0; k < 64; k++) begin
      rd = 16'($random(seed));
      far_loop_mode_companion = k[0];
      channel_powerdown_n = (k % 5) != 1;
      global_powerdown = (k % 7) == 3;
      // only the two legal bandwidth codes
      set_ctl({rd[15:10], rd[8], ~rd[8], k[1], rd[6:4], k[5:2]});
      check_outputs();
      reg_read(LSLC_ADDR_PLL_CTRL, rd);
      check(rd, ctl_m);
    end
    // Companion bit off so later random modes never reach pad loop
    far_loop_mode_companion = 1'b0;
    // Same-edge read and write returns the old value
    @(posedge sys_clk);
    #2 reg_wr = 1'b1;
    reg_rd = 1'b1;
    reg_addr = LSLC_ADDR_PLL_CTRL;
    reg_wdata = 16'h5A12;
    @(posedge sys_clk);
    #2 reg_wr = 1'b0;
    reg_rd = 1'b0;
    check(reg_rdata, ctl_m);
    ctl_m = 16'h5A12;
    // Masked companion writes, corners 0000 and 1111 first
    for (k = 0; k < 24; k++) begin
      rd = 16'($random(seed));
      // only the two legal bandwidth codes
      rd[9:8] = {rd[8], ~rd[8]};
      if (k == 0) rd[15:12] = 4'h0;
      if (k == 1) rd[15:12] = 4'hF;
      set_ctl(rd);
      rd = 16'($random(seed));
      reg_write(LSLC_ADDR_LANE_B, rd);
      for (i = 0; i < 4; i++) if (ctl_m[12 + i]) b_m[i] = rd;
      // test enables kept set while loopback may be on
      rd = 16'($random(seed)) | 16'h000C;
      reg_write(LSLC_ADDR_LANE_C, rd);
      for (i = 0; i < 4; i++) if (ctl_m[12 + i]) c_m[i] = rd;
      if (k % 4 == 0) check_lanes();
    end
    check_lanes();
    // Second reset in mid-run restores defaults
    do_reset();
    reg_read(LSLC_ADDR_PLL_CTRL, rd);
    check(rd, 16'hF115);
    check_outputs();
    check_lanes();
    stop_test();
  end
endmodule
